// File: logic/socket_power_clock_map.vh
// Register map, field layout, reset values and timing counts for the socket
// power and card clock register bank.
// Assumes byte addresses on a 32-bit APB with one aligned word per register.
`ifndef SOCKET_POWER_CLOCK_MAP_VH
`define SOCKET_POWER_CLOCK_MAP_VH

// Register byte offsets
`define OFS_SOCKET_POWER_REQUEST  8'h10
`define OFS_CARD_CLOCK_CONTROL    8'h20
`define OFS_POWER_STATUS          8'h30
`define OFS_VOLTAGE_FORCE         8'h34

// Reset values
`define RST_SOCKET_POWER_REQUEST  32'h00000000
`define RST_CARD_CLOCK_CONTROL    32'h00000000

// Socket power request fields
`define VCC_REQ_MSB               6
`define VCC_REQ_LSB               4
`define VPP_REQ_MSB               2
`define VPP_REQ_LSB               0

// Supply codes
`define SUPPLY_OFF                3'h0
`define VPP_12V                   3'h1
`define SUPPLY_5V                 3'h2
`define SUPPLY_3V3                3'h3

// Card clock control fields
`define BIT_HALT_CARD_CLOCK       0
`define BIT_CLOCK_START_INHIBIT   1

// Power status fields
`define BIT_POWER_UP_DONE         3
`define BIT_CAP_5V                8
`define BIT_CAP_3V                9
`define BIT_CAPS_FORCED           10

// Voltage force fields
`define BIT_FORCE_5V              10
`define BIT_FORCE_3V              11
`define BIT_RECHECK_VOLTAGE_SENSE 14

// Card clock periods between the halt bit driving the run line high and stopping the clock
`define HALT_CLOCK_PERIODS        3'h4

`endif

// File: logic/socket_power_clock_regs.v
// Socket power request and card clock control registers with their socket-side logic.
// Assumes an APB master on pclk, and card-side pins that are asynchronous to pclk
// (card clock source, clock run line, voltage sense) and are synchronised here.
// Assumes the card clock source has at least four pclk periods in each half period.
// Assumes the power switch acts on vcc_select and vpp_select as they stand.
//
// Operation
// - The card supply request field, bits 6..4, codes off as 000, 5 V as 010 and 3.3 V as 011.
// - The programming supply field, bits 2..0, codes off 000, 12 V 001, 5 V 010, 3.3 V 011.
// - Reserved bits of both registers always read as zero.
// - The socket power register is a 32-bit read/write register that resets to zero.
// - The card clock control register is 32 bits wide and resets to zero.
// - With the halt and start inhibit bits clear the card clock runs and the run line is held asserted.
// - With the start inhibit bit set the clock stops whenever the card does not assert run.
// - Setting the halt bit drives the run line high and stops the clock 4 periods later.
// - After each power request the power-up done status shows whether the socket is powered.
// - Forced voltage flags never power the card supply until a voltage recheck is written.
`timescale 1ns/10ps
`include "socket_power_clock_map.vh"

module socket_power_clock_regs (
  input  wire        pclk,
  input  wire        presetn,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [7:0]  paddr,
  input  wire [31:0] pwdata,
  output wire [31:0] prdata,
  output wire        pready,
  output wire        pslverr,
  input  wire        clock_source,
  output reg         card_clock,
  input  wire        card_clock_run_n_in,
  output reg         card_clock_run_n_out,
  output reg         card_clock_run_n_oe,
  input  wire        sense_5v,
  input  wire        sense_3v,
  output reg  [2:0]  vcc_select,
  output reg  [2:0]  vpp_select
);

  // Software-visible state
  reg  [2:0]  vcc_request;
  reg  [2:0]  vpp_request;
  reg         halt_card_clock;
  reg         clock_start_inhibit;
  reg         power_up_done;
  // Card voltage capability and whether software forced it
  reg         cap_5v;
  reg         cap_3v;
  reg         caps_forced;
  reg         eval_pending;

  // Card-side pins, gathered into one bank for the synchronisers
  localparam PIN_SRC = 0;
  localparam PIN_RUN = 1;
  localparam PIN_S5  = 2;
  localparam PIN_S3  = 3;
  localparam PINS    = 4;
  // Reset level of each stage: the run line rests high on its pull-up, the rest low
  localparam [3:0] PIN_IDLE = 4'h2;
  wire [3:0]  pin_raw;
  wire [3:0]  pin_sync;
  reg         src_prev;

  // Reset contents of the two registers, split into fields below
  localparam [31:0] POWER_RESET = `RST_SOCKET_POWER_REQUEST;
  localparam [31:0] CLOCK_RESET = `RST_CARD_CLOCK_CONTROL;

  // Card clock sequencing
  reg  [2:0]  halt_count;
  reg         clock_on;

  // Bus decode
  wire        access;
  wire        wr;
  wire        hit_power;
  wire        hit_clock;
  wire        hit_status;
  wire        hit_force;
  wire        mapped;
  reg  [31:0] read_word;

  // Card-side decode and the clock decision
  wire        src_level;
  wire        src_rise;
  wire        card_runs;
  wire        vcc_valid;
  wire        vpp_valid;
  wire        vcc_allowed;
  reg         want_clock;

  // Zero-wait APB slave; the access phase completes in its first cycle
  // Writes land at the edge that ends the access phase
  assign pready     = 1'b1;
  assign access     = psel & penable;
  assign wr         = access & pwrite;
  assign hit_power  = (paddr == `OFS_SOCKET_POWER_REQUEST);
  assign hit_clock  = (paddr == `OFS_CARD_CLOCK_CONTROL);
  assign hit_status = (paddr == `OFS_POWER_STATUS);
  assign hit_force  = (paddr == `OFS_VOLTAGE_FORCE);
  assign mapped     = hit_power | hit_clock | hit_status | hit_force;
  // Unmapped addresses answer with an error and are never written
  assign pslverr    = access & ~mapped;

  // Read multiplexer; every bit not listed reads as zero
  always @* begin
    read_word = 32'h00000000;
    if (hit_power) begin
      read_word[`VCC_REQ_MSB:`VCC_REQ_LSB] = vcc_request;
      read_word[`VPP_REQ_MSB:`VPP_REQ_LSB] = vpp_request;
    end else if (hit_clock) begin
      read_word[`BIT_HALT_CARD_CLOCK]     = halt_card_clock;
      read_word[`BIT_CLOCK_START_INHIBIT] = clock_start_inhibit;
    end else if (hit_status) begin
      // Status reports the supplies actually applied, not the request
      read_word[`VCC_REQ_MSB:`VCC_REQ_LSB] = vcc_select;
      read_word[`VPP_REQ_MSB:`VPP_REQ_LSB] = vpp_select;
      read_word[`BIT_POWER_UP_DONE]        = power_up_done;
      read_word[`BIT_CAP_5V]               = cap_5v;
      read_word[`BIT_CAP_3V]               = cap_3v;
      read_word[`BIT_CAPS_FORCED]          = caps_forced;
    end
  end

  // Read data is only presented during a read access
  // Zero outside reads keeps the read lines quiet between transfers
  assign prdata = (access & ~pwrite) ? read_word : 32'h00000000;

  // Request and control registers, written at the completing access edge
  // Reserved bits of a write are dropped here, so they never read back
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      vcc_request         <= POWER_RESET[`VCC_REQ_MSB:`VCC_REQ_LSB];
      vpp_request         <= POWER_RESET[`VPP_REQ_MSB:`VPP_REQ_LSB];
      halt_card_clock     <= CLOCK_RESET[`BIT_HALT_CARD_CLOCK];
      clock_start_inhibit <= CLOCK_RESET[`BIT_CLOCK_START_INHIBIT];
    end else if (wr) begin
      if (hit_power) begin
        vcc_request <= pwdata[`VCC_REQ_MSB:`VCC_REQ_LSB];
        vpp_request <= pwdata[`VPP_REQ_MSB:`VPP_REQ_LSB];
      end
      // Clock control stays writable so that halt and inhibit can be used
      if (hit_clock) begin
        halt_card_clock     <= pwdata[`BIT_HALT_CARD_CLOCK];
        clock_start_inhibit <= pwdata[`BIT_CLOCK_START_INHIBIT];
      end
    end
  end

  // Two-flop synchroniser per card-side pin; only the second stage is read
  // The run line passes the same bank as the other pins, so all share one latency
  assign pin_raw = {sense_3v, sense_5v, card_clock_run_n_in, clock_source};

  genvar pin;
  generate
    for (pin = 0; pin < PINS; pin = pin + 1) begin : g_pin_sync
      reg [1:0] stage;
      always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          stage <= {2{PIN_IDLE[pin]}};
        end else begin
          stage <= {stage[0], pin_raw[pin]};
        end
      end
      assign pin_sync[pin] = stage[1];
    end
  endgenerate

  // Previous synchronised source level, for finding its rising edges
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      src_prev <= 1'b0;
    end else begin
      src_prev <= src_level;
    end
  end

  assign src_level = pin_sync[PIN_SRC];
  assign src_rise  = src_level & ~src_prev;
  assign card_runs = ~pin_sync[PIN_RUN];

  // Voltage capability: sampled from sense pins, or forced by software
  // A recheck outranks force bits written in the same word
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cap_5v      <= 1'b0;
      cap_3v      <= 1'b0;
      caps_forced <= 1'b0;
    end else if (wr && hit_force) begin
      if (pwdata[`BIT_RECHECK_VOLTAGE_SENSE]) begin
        cap_5v      <= pin_sync[PIN_S5];
        cap_3v      <= pin_sync[PIN_S3];
        caps_forced <= 1'b0;
      end else if (pwdata[`BIT_FORCE_5V] | pwdata[`BIT_FORCE_3V]) begin
        cap_5v      <= pwdata[`BIT_FORCE_5V];
        cap_3v      <= pwdata[`BIT_FORCE_3V];
        caps_forced <= 1'b1;
      end
    end
  end

  // Codes accepted for each supply
  // A card supply the card cannot take counts as a failed power-up
  assign vcc_valid = (vcc_request == `SUPPLY_OFF) | (vcc_request == `SUPPLY_5V) |
                     (vcc_request == `SUPPLY_3V3);
  assign vpp_valid = (vpp_request[2] == 1'b0);
  assign vcc_allowed = ~caps_forced &
                       (((vcc_request == `SUPPLY_5V) & cap_5v) |
                        ((vcc_request == `SUPPLY_3V3) & cap_3v));

  // Evaluate a request the cycle after a power write or a recheck
  // One cycle later, a recheck already sees the freshly sampled capability flags
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      eval_pending <= 1'b0;
    end else begin
      eval_pending <= wr & (hit_power | (hit_force & pwdata[`BIT_RECHECK_VOLTAGE_SENSE]));
    end
  end

  // Supplies applied to the socket and the power-up result
  // A reserved code in one field leaves that supply and the status alone
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      vcc_select    <= `SUPPLY_OFF;
      vpp_select    <= `SUPPLY_OFF;
      power_up_done <= 1'b0;
    end else if (eval_pending) begin
      if (vpp_valid) begin
        vpp_select <= vpp_request;
      end
      if (vcc_valid) begin
        if (vcc_request == `SUPPLY_OFF) begin
          vcc_select    <= `SUPPLY_OFF;
          power_up_done <= 1'b0;
        end else if (vcc_allowed) begin
          vcc_select    <= vcc_request;
          power_up_done <= 1'b1;
        end else begin
          vcc_select    <= `SUPPLY_OFF;
          power_up_done <= 1'b0;
        end
      end
    end
  end

  // Count card clock periods once halting has been requested
  // Source edges keep the delay in card clock periods; the count stops at its limit
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      halt_count <= 3'h0;
    end else if (!halt_card_clock) begin
      halt_count <= 3'h0;
    end else if (src_rise && (halt_count != `HALT_CLOCK_PERIODS)) begin
      halt_count <= halt_count + 3'h1;
    end
  end

  // Decide whether the card clock should run
  // Halt outranks the start inhibit, so software can always stop the clock
  always @* begin
    if (halt_card_clock) begin
      want_clock = (halt_count != `HALT_CLOCK_PERIODS);
    end else if (!clock_start_inhibit) begin
      want_clock = 1'b1;
    end else begin
      want_clock = card_runs;
    end
  end

  // Gate the clock only while the source is low, so no runt pulse reaches the card
  // A stop or start decided in a high phase waits for the next low phase
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      clock_on   <= 1'b1;
      card_clock <= 1'b0;
    end else begin
      if (!src_level) begin
        clock_on <= want_clock;
      end
      card_clock <= clock_on & src_level;
    end
  end

  // Clock run line: halted drives high, free running drives low, else released
  // Released leaves the level to the card and the socket pull-up
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      card_clock_run_n_out <= 1'b1;
      card_clock_run_n_oe  <= 1'b0;
    end else if (halt_card_clock) begin
      card_clock_run_n_out <= 1'b1;
      card_clock_run_n_oe  <= 1'b1;
    end else if (!clock_start_inhibit) begin
      card_clock_run_n_out <= 1'b0;
      card_clock_run_n_oe  <= 1'b1;
    end else begin
      card_clock_run_n_out <= 1'b1;
      card_clock_run_n_oe  <= 1'b0;
    end
  end

endmodule // socket_power_clock_regs

// File: bench/socket_power_clock_regs_asserts.sv
// Checker for the socket power and card clock register bank.
// Assumes it is bound to the top module and sees only its ports.
`timescale 1ns/10ps
module socket_power_clock_regs_asserts (
  input wire        pclk,
  input wire        presetn,
  input wire        psel,
  input wire        penable,
  input wire        pwrite,
  input wire [7:0]  paddr,
  input wire [31:0] pwdata,
  input wire [31:0] prdata,
  input wire        card_clock,
  input wire        card_clock_run_n_in,
  input wire        card_clock_run_n_out,
  input wire        card_clock_run_n_oe,
  input wire [2:0]  vcc_select,
  input wire [2:0]  vpp_select
);
  wire       wr  = psel && penable && pwrite;
  wire       rd  = psel && penable && !pwrite;
  wire       pw  = wr && paddr == 8'h10;
  reg  [1:0] ctl;
  reg  [6:0] hcnt;
  reg  [6:0] icnt;
  // Shadow of the clock controls and cycles spent halted or without run
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctl  <= 2'h0;
      hcnt <= 7'h00;
      icnt <= 7'h00;
    end else begin
      if (wr && paddr == 8'h20) ctl <= pwdata[1:0];
      hcnt <= !ctl[0] ? 7'h00 : hcnt + {6'h00, !hcnt[6]};
      icnt <= !(ctl == 2'h2 && card_clock_run_n_in) ? 7'h00 : icnt + {6'h00, !icnt[6]};
    end
  end
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  a_power_rsvd_zero: assert property (rd && paddr == 8'h10 |-> prdata[31:7] == 25'h0 && !prdata[3])
    else $error("power register reserved bits set");
  a_card_clock_control_rsvd_zero: assert property (rd && paddr == 8'h20 |-> prdata[31:2] == 30'h0)
    else $error("clock control reserved bits set");
  a_vcc_code_legal: assert property (vcc_select == 3'h0 || vcc_select[2:1] == 2'h1)
    else $error("card supply code not legal");
  a_vcc_off_req: assert property (pw && pwdata[6:4] == 3'h0 |-> ##2 vcc_select == 3'h0)
    else $error("card supply not off");
  a_vpp_applied: assert property (pw && !pwdata[2] |-> ##2 vpp_select == $past(pwdata[2:0], 2))
    else $error("programming supply not applied");
  a_vpp_rsvd_keep: assert property (pw && pwdata[2] |-> ##2 $stable(vpp_select))
    else $error("programming supply changed");
  a_vcc_rsvd_keep: assert property (pw && (pwdata[6] || pwdata[6:4] == 3'h1) |-> ##2 $stable(vcc_select))
    else $error("card supply changed");
  a_run_driven: assert property ((ctl == 2'h0)[*2] |-> card_clock_run_n_oe && !card_clock_run_n_out)
    else $error("run line not driven low");
  a_halt_run_high: assert property (ctl[0][*2] |-> card_clock_run_n_oe && card_clock_run_n_out)
    else $error("run line not driven high");
  a_halt_delayed: assert property ($rose(ctl[0]) && !ctl[1] |-> ##[1:12] $rose(card_clock) ##[1:12] $rose(card_clock))
    else $error("clock stopped too early");
  a_halt_stops: assert property (hcnt[6] |-> !card_clock)
    else $error("clock runs while halted");
  a_inhibit_release: assert property ((ctl == 2'h2)[*2] |-> !card_clock_run_n_oe)
    else $error("run line still driven");
  a_inhibit_stops: assert property (icnt[6] |-> !card_clock)
    else $error("clock runs without run request");
endmodule // socket_power_clock_regs_asserts

bind socket_power_clock_regs socket_power_clock_regs_asserts u_chk (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .card_clock(card_clock),
  .card_clock_run_n_in(card_clock_run_n_in), .card_clock_run_n_out(card_clock_run_n_out),
  .card_clock_run_n_oe(card_clock_run_n_oe), .vcc_select(vcc_select), .vpp_select(vpp_select));

// File: bench/card_socket_model.sv
// Card in the socket: resolves the clock run line, which has a pull-up.
// Assumes the bench says when the card wants its clock kept running.
`timescale 1ns/10ps
module card_socket_model (
  input  wire run_n_oe,
  input  wire run_n_out,
  input  wire card_wants_run,
  output wire run_n_level
);
  // Low while the host or the card pulls it down, else pulled high
  assign run_n_level = (run_n_oe && !run_n_out) || card_wants_run ? 1'b0 : 1'b1;
endmodule // card_socket_model

// File: bench/socket_power_clock_regs_tb.sv
// Self-checking bench for the socket power and card clock registers.
// Assumes the card model on the run line and an 80 ns card clock source.
`timescale 1ns/10ps
module socket_power_clock_regs_tb;
  logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, rerr;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, rdat, d, m_reg = 0;
  logic        clock_source = 0, sense_5v = 0, sense_3v = 0, card_run = 0;
  wire  [31:0] prdata;
  wire         pready, pslverr, card_clock, run_out, run_oe, run_lvl;
  wire  [2:0]  vcc_select, vpp_select;
  integer      n_mismatch = 0, checked = 0, nr, k, m_vcc = 0, m_vpp = 0, m_pud = 0, m_frc = 0;

  socket_power_clock_regs u_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .clock_source(clock_source), .card_clock(card_clock),
    .card_clock_run_n_in(run_lvl), .card_clock_run_n_out(run_out), .card_clock_run_n_oe(run_oe),
    .sense_5v(sense_5v), .sense_3v(sense_3v), .vcc_select(vcc_select), .vpp_select(vpp_select));
  card_socket_model u_card (.run_n_oe(run_oe), .run_n_out(run_out), .card_wants_run(card_run),
    .run_n_level(run_lvl));

  // Bus clock and a card clock source of unrelated phase
  initial forever #5 pclk = ~pclk;
  initial begin
    #3;
    forever #40 clock_source = ~clock_source;
  end

  task summarize;
    $display("mismatches %0d checks %0d", n_mismatch, checked);
    if (n_mismatch == 0 && checked > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task chk(input string n, input logic [31:0] e, input logic [31:0] g);
    checked++;
    if (g !== e) begin
      n_mismatch++;
      $display("Error %s expected %h seen %h", n, e, g);
    end
  endtask
  // One APB transfer: setup, access until pready at an edge, then an idle edge
  task apb(input logic w, input logic [7:0] a, input logic [31:0] v);
    integer i;
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= v;
    @(posedge pclk);
    penable <= 1;
    i = 0;
    @(posedge pclk);
    while (pready !== 1'b1 && i < 16) begin
      @(posedge pclk);
      i++;
    end
    if (pready !== 1'b1) begin
      n_mismatch++;
      summarize;
    end
    rdat = prdata;
    rerr = pslverr;
    psel <= 0;
    penable <= 0;
    @(posedge pclk);
  endtask
  // Card clock rising edges seen over n cycles
  task rises(input integer n);
    integer i;
    logic p;
    nr = 0;
    p = card_clock;
    for (i = 0; i < n; i++) begin
      @(negedge pclk);
      if (card_clock && !p) nr++;
      p = card_clock;
    end
    @(posedge pclk);
  endtask
  // Reference model of the applied card supply
  task apply(input logic [2:0] c);
    if (c == 3'h0) m_vcc = 0;
    else if (c == 3'h2) m_vcc = sense_5v && !m_frc ? 2 : 0;
    else if (c == 3'h3) m_vcc = sense_3v && !m_frc ? 3 : 0;
    if (c == 3'h0 || c[2:1] == 2'h1) m_pud = m_vcc != 0;
  endtask
  task check_pwr;
    apb(0, 8'h30, 32'h0);
    chk("vcc applied", m_vcc, vcc_select);
    chk("vpp applied", m_vpp, vpp_select);
    chk("status", m_vcc * 16 + m_pud * 8 + m_vpp, rdat & 32'h7F);
  endtask
  task recheck;
    repeat (4) @(posedge pclk);
    apb(1, 8'h34, 32'h4000);
    m_frc = 0;
    apply(m_reg[6:4]);
    check_pwr;
  endtask
  task power(input logic [31:0] v);
    apb(1, 8'h10, v);
    m_reg = v & 32'h77;
    apply(v[6:4]);
    if (!v[2]) m_vpp = v[2:0];
    apb(0, 8'h10, 32'h0);
    chk("power request", m_reg, rdat);
    check_pwr;
  endtask

  initial begin
    k = $urandom(24);
    repeat (10) @(posedge pclk);
    presetn <= 1;
    @(posedge pclk);
    apb(0, 8'h10, 32'h0);
    chk("power reset", 32'h0, rdat);
    apb(0, 8'h20, 32'h0);
    chk("card_clock_control reset", 32'h0, rdat);
    chk("run drive", 2'h2, {run_oe, run_out});
    rises(80);
    chk("clock runs", 1, nr > 5);
    $display("test reset done");
    sense_3v <= 1;
    recheck;
    apb(1, 8'h34, 32'h400);
    m_frc = 1;
    power(32'h20);
    sense_5v <= 1;
    recheck;
    $display("test forced caps done");
    for (k = 0; k < 16; k++) begin
      d = $urandom;
      if (k < 8) d[6:4] = k[2:0];
      if (k < 8) d[2:0] = k[2:0];
      sense_5v <= $urandom % 2;
      sense_3v <= $urandom % 2;
      recheck;
      power(d);
    end
    apb(0, 8'h40, 32'h0);
    chk("unmapped data", 32'h0, rdat);
    chk("unmapped error", 1, rerr);
    $display("test power codes done");
    card_run <= 1;
    apb(1, 8'h20, 32'h2);
    rises(80);
    chk("run kept", 1, nr > 5);
    chk("run released", 0, run_oe);
    card_run <= 0;
    rises(64);
    rises(40);
    chk("run stopped", 0, nr);
    apb(1, 8'h20, 32'h0);
    rises(80);
    apb(1, 8'h20, 32'h1);
    rises(80);
    chk("rises before halt", 1, nr >= 3 && nr <= 5);
    rises(40);
    chk("halted", 0, nr);
    chk("halt drive", 2'h3, {run_oe, run_out});
    apb(1, 8'h20, 32'hFFFFFFFF);
    apb(0, 8'h20, 32'h0);
    chk("card_clock_control bits", 32'h3, rdat);
    $display("test card clock done");
    summarize;
  end
endmodule // socket_power_clock_regs_tb
